// >>> shared/switch_scanner_defs.vh
// constants of the thumbwheel switch scanner
`ifndef SWITCH_SCANNER_DEFS_VH
`define SWITCH_SCANNER_DEFS_VH
// ****************
// bus offsets
// ****************
`define OFS_CTRL 8'h00
`define OFS_PTR 8'h04
`define OFS_STAT 8'h08
`define OFS_ISTS 8'h0C
`define OFS_IMASK 8'h10
`define OFS_GPOUT 8'h14
`define OFS_GPIN 8'h18
`define OFS_ROUNDS 8'h1C
`define OFS_AREA 8'h40
// ****************
// fields and resets
// ****************
`define CTRL_RUN 0
`define CTRL_IND 1
`define CTRL_RST 2'h1
`define EV_ROUND 0
`define EV_ERR 1
`define SCAN_BITS 5
`define ROUND_BIT 5
`define AREA_LAST 14'h000F
`define PHASE_LAST 3'h4
`define PHASE_SAMPLE 3'h3
`define PAIR_LAST 2'h3
// ****************
// timing
// ****************
`define CLK_PERIOD_NS 5
`define EXEC_PERIOD_NS 1000
`define EXEC_CYCLES (`EXEC_PERIOD_NS / `CLK_PERIOD_NS)
`endif

// >>> hdl/exec_tick.v
// execution step divider
`timescale 1ns/100ps
`default_nettype none
`include "switch_scanner_defs.vh"
module exec_tick (
	// clock and reset
	input wire core_clk,
	input wire rst_n,
	// control
	input wire enable,
	output reg tick
);
	localparam [31:0] LAST_W = `EXEC_CYCLES - 1;
	localparam [7:0] LAST = LAST_W[7:0];
	reg [7:0] cnt_q;
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 8'h00;
			tick <= 1'b0;
		end else if (!enable) begin
			cnt_q <= 8'h00;
			tick <= 1'b0;
		end else begin
			tick <= (cnt_q == LAST);
			cnt_q <= (cnt_q == LAST) ? 8'h00 : cnt_q + 8'h01;
		end
	end
endmodule // exec_tick
`default_nettype wire

// >>> hdl/result_store.v
// result word area, sixteen words
`timescale 1ns/100ps
`default_nettype none
module result_store (
	// clock and reset
	input wire core_clk,
	input wire rst_n,
	// write port
	input wire we,
	input wire [3:0] waddr,
	input wire [15:0] wdata,
	// read port
	input wire [3:0] raddr,
	output reg [15:0] rdata
);
	reg [15:0] mem [0:15];
	always @(posedge core_clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 16'h0000;
		end else begin
			rdata <= mem[raddr];
		end
	end
endmodule // result_store
`default_nettype wire

// >>> hdl/switch_scanner.v
// thumbwheel switch scanner with wishbone registers
//
// The Wishbone register port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "switch_scanner_defs.vh"
module switch_scanner (
	// clock and reset
	input wire core_clk,
	input wire rst_n,
	// wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	// switch bank
	input wire [15:0] switch_input_word,
	output reg [15:0] select_output_word,
	// status
	output wire switch_read_busy_flag,
	output reg operand_error_flag,
	output wire irq
);
	// ****************
	// register state
	// ****************
	reg [1:0] ctrl_q;
	reg [15:0] ptr_q;
	reg [1:0] ists_q;
	reg [1:0] imask_q;
	reg [15:0] gpo_q;
	reg [15:0] rounds_q;
	reg pend_q;
	wire req;
	wire wr_acc;
	wire run;
	assign req = wb_cyc_i & wb_stb_i;
	assign wr_acc = wb_ack_o & req & wb_we_i;
	assign run = ctrl_q[`CTRL_RUN];
	// ****************
	// scan state
	// ****************
	reg [2:0] phase_q;
	reg [1:0] pair_q;
	reg [15:0] in_q;
	reg [4:0] scan_q;
	reg round_q;
	reg wr_lo_q;
	reg wr_hi_q;
	reg run_q;
	wire tick;
	wire step;
	wire cap;
	wire last_step;
	wire [15:0] lo_word;
	wire [15:0] hi_word;
	assign step = tick & run;
	assign cap = step & (phase_q == `PHASE_SAMPLE);
	assign last_step = step & (phase_q == `PHASE_LAST) & (pair_q == `PAIR_LAST);
	exec_tick u_tick (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.enable(run),
		.tick(tick)
	);
	// ****************
	// pointer check
	// ****************
	reg bcd_ok;
	reg [13:0] bcd_val;
	reg [13:0] eff;
	reg err_d;
	always @* begin
		bcd_ok = (ptr_q[3:0] < 4'hA) & (ptr_q[7:4] < 4'hA) &
			(ptr_q[11:8] < 4'hA) & (ptr_q[15:12] < 4'hA);
		bcd_val = ({10'h000, ptr_q[15:12]} * 14'h03E8) +
			({10'h000, ptr_q[11:8]} * 14'h0064) +
			({10'h000, ptr_q[7:4]} * 14'h000A) + {10'h000, ptr_q[3:0]};
		eff = ctrl_q[`CTRL_IND] ? bcd_val : ptr_q[13:0];
		err_d = 1'b0;
		if (ctrl_q[`CTRL_IND] && !bcd_ok) begin
			err_d = 1'b1;
		end
		if (eff > `AREA_LAST) begin
			err_d = 1'b1;
		end
		if (eff == `AREA_LAST) begin
			err_d = 1'b1;
		end
	end
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			operand_error_flag <= 1'b0;
		end else begin
			operand_error_flag <= run & err_d;
		end
	end
	// ****************
	// scan sequencer
	// ****************
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_q <= 3'h0;
			pair_q <= 2'h0;
			run_q <= 1'b0;
		end else begin
			run_q <= run;
			if (!run) begin
				phase_q <= 3'h0;
				pair_q <= 2'h0;
			end else if (step) begin
				if (phase_q == `PHASE_LAST) begin
					phase_q <= 3'h0;
					pair_q <= pair_q + 2'h1;
				end else begin
					phase_q <= phase_q + 3'h1;
				end
			end
		end
	end
	// outputs and inputs refreshed on each execution
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			in_q <= 16'h0000;
			scan_q <= 5'h00;
			round_q <= 1'b0;
		end else if (!run) begin
			scan_q <= 5'h00;
			round_q <= 1'b0;
		end else if (step) begin
			in_q <= switch_input_word;
			scan_q[3:0] <= 4'h0;
			scan_q[4] <= 1'b0;
			if (phase_q == `PHASE_LAST) begin
				scan_q[pair_q + 2'h1] <= 1'b1;
			end else if (phase_q != `PHASE_SAMPLE) begin
				scan_q[pair_q] <= 1'b1;
				scan_q[4] <= 1'b1;
			end
			round_q <= last_step;
		end
	end
	// digit capture, one nibble pair per select line
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : dig
			reg [3:0] lo_q;
			reg [3:0] hi_q;
			always @(posedge core_clk or negedge rst_n) begin
				if (!rst_n) begin
					lo_q <= 4'h0;
					hi_q <= 4'h0;
				end else if (cap && pair_q == g) begin
					lo_q <= in_q[3:0];
					hi_q <= in_q[7:4];
				end
			end
			assign lo_word[4 * g + 3:4 * g] = lo_q;
			assign hi_word[4 * g + 3:4 * g] = hi_q;
		end
	endgenerate
	// ****************
	// result writes
	// ****************
	reg [3:0] base_q;
	wire mem_we;
	wire [3:0] mem_waddr;
	wire [15:0] mem_wdata;
	wire [15:0] mem_rdata;
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_lo_q <= 1'b0;
			wr_hi_q <= 1'b0;
			base_q <= 4'h0;
			rounds_q <= 16'h0000;
		end else begin
			wr_lo_q <= last_step & ~err_d;
			wr_hi_q <= wr_lo_q;
			if (last_step) begin
				base_q <= eff[3:0];
				rounds_q <= rounds_q + 16'h0001;
			end
		end
	end
	assign mem_we = wr_lo_q | wr_hi_q;
	assign mem_waddr = wr_hi_q ? base_q + 4'h1 : base_q;
	assign mem_wdata = wr_hi_q ? hi_word : lo_word;
	result_store u_store (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.we(mem_we),
		.waddr(mem_waddr),
		.wdata(mem_wdata),
		.raddr(wb_adr_i[5:2]),
		.rdata(mem_rdata)
	);
	// ****************
	// output word
	// ****************
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			select_output_word <= 16'h0000;
		end else begin
			select_output_word <= {gpo_q[15:6], round_q, scan_q};
		end
	end
	assign switch_read_busy_flag = run;
	// ****************
	// interrupts
	// ****************
	wire [1:0] ev;
	assign ev[`EV_ROUND] = last_step;
	assign ev[`EV_ERR] = run & err_d & ~operand_error_flag;
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ists_q <= 2'h0;
		end else if (wr_acc && wb_adr_i == `OFS_ISTS && wb_sel_i[0]) begin
			ists_q <= (ists_q & ~wb_dat_i[1:0]) | ev;
		end else begin
			ists_q <= ists_q | ev;
		end
	end
	assign irq = |(ists_q & imask_q);
	// ****************
	// bus slave
	// ****************
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_q <= 1'b0;
			wb_ack_o <= 1'b0;
		end else begin
			pend_q <= req & ~pend_q & ~wb_ack_o;
			wb_ack_o <= pend_q & req;
		end
	end
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= `CTRL_RST;
			ptr_q <= 16'h0000;
			imask_q <= 2'h0;
			gpo_q <= 16'h0000;
		end else if (wr_acc) begin
			case (wb_adr_i)
				`OFS_CTRL: begin
					if (wb_sel_i[0]) begin
						ctrl_q <= wb_dat_i[1:0];
					end
				end
				`OFS_PTR: begin
					if (wb_sel_i[0]) begin
						ptr_q[7:0] <= wb_dat_i[7:0];
					end
					if (wb_sel_i[1]) begin
						ptr_q[15:8] <= wb_dat_i[15:8];
					end
				end
				`OFS_IMASK: begin
					if (wb_sel_i[0]) begin
						imask_q <= wb_dat_i[1:0];
					end
				end
				`OFS_GPOUT: begin
					if (wb_sel_i[0]) begin
						gpo_q[7:0] <= wb_dat_i[7:0];
					end
					if (wb_sel_i[1]) begin
						gpo_q[15:8] <= wb_dat_i[15:8];
					end
				end
				default: begin
					ctrl_q <= ctrl_q;
				end
			endcase
		end
	end
	// read data registered on the same edge that raises ack
	reg [31:0] rd_d;
	always @* begin
		rd_d = 32'h00000000;
		if (wb_adr_i[7:6] == 2'h1) begin
			rd_d = {16'h0000, mem_rdata};
		end else begin
			case (wb_adr_i)
				`OFS_CTRL: rd_d = {30'h00000000, ctrl_q};
				`OFS_PTR: rd_d = {16'h0000, ptr_q};
				`OFS_STAT: rd_d = {19'h00000, pair_q, phase_q, 5'h00,
					round_q, operand_error_flag, run};
				`OFS_ISTS: rd_d = {30'h00000000, ists_q};
				`OFS_IMASK: rd_d = {30'h00000000, imask_q};
				`OFS_GPOUT: rd_d = {16'h0000, gpo_q};
				`OFS_GPIN: rd_d = {16'h0000, switch_input_word};
				`OFS_ROUNDS: rd_d = {16'h0000, rounds_q};
				default: rd_d = 32'h00000000;
			endcase
		end
	end
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_dat_o <= 32'h00000000;
		end else if (pend_q) begin
			wb_dat_o <= rd_d;
		end
	end
endmodule // switch_scanner
`default_nettype wire

// >>> bench/switch_scanner_props.sv
// assertions on the switch scanner ports
`timescale 1ns/100ps
`default_nettype none
module switch_scanner_props (
	// clock and reset
	input wire core_clk,
	input wire rst_n,
	// observed
	input wire wb_ack_o,
	input wire wb_we_i,
	input wire [15:0] select_output_word,
	input wire switch_read_busy_flag,
	input wire operand_error_flag
);
	int cnt_q;
	logic seen_q;
	wire [15:0] s = select_output_word;
	wire bz = switch_read_busy_flag;
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 0;
			seen_q <= 1'h0;
		end else if (!bz) begin
			cnt_q <= 0;
			seen_q <= 1'h0;
		end else if ($rose(s[5])) begin
			cnt_q <= 0;
			seen_q <= 1'h1;
		end else begin
			cnt_q <= cnt_q + 1;
		end
	end
	a_idle_still: assert property (!bz && !$past(bz) && !$past(bz, 2) && !$past(bz, 3)
		|-> $stable(s[5:0]))
		else $error("scan lines moved while idle");
	a_round_gap: assert property ($rose(s[5]) && seen_q |-> cnt_q == 3999)
		else $error("round length wrong");
	a_round_len: assert property ($rose(s[5]) |-> s[5] [*8])
		else $error("round flag too short");
	a_busy_start: assert property ($rose(rst_n) |-> bz)
		else $error("not scanning after reset");
	a_sel_step: assert property ($changed(s[4:0]) |=> $stable(s[4:0]) [*8])
		else $error("scan lines moved inside a step");
	a_free_bits: assert property ($changed(s[15:6]) |-> $past(wb_ack_o && wb_we_i, 2))
		else $error("free outputs moved without write");
	a_err_busy: assert property (operand_error_flag |-> $past(bz))
		else $error("error flag while idle");
	a_sel_one: assert property ($onehot0(s[3:0]) && (!s[4] || (|s[3:0])))
		else $error("bad select pattern");
	c_round: cover property ($rose(s[5]));
	c_err: cover property ($rose(operand_error_flag));
	c_idle: cover property ($fell(bz));
endmodule // switch_scanner_props
bind switch_scanner switch_scanner_props i_props (
	.core_clk(core_clk),
	.rst_n(rst_n),
	.wb_ack_o(wb_ack_o),
	.wb_we_i(wb_we_i),
	.select_output_word(select_output_word),
	.switch_read_busy_flag(switch_read_busy_flag),
	.operand_error_flag(operand_error_flag)
);
`default_nettype wire

// >>> bench/switch_bank.sv
// switch bank model with latched digit outputs
`timescale 1ns/100ps
`default_nettype none
module switch_bank (
	// scan lines
	input wire logic [15:0] select_output_word,
	// set digits and free inputs
	input wire logic [15:0] dig_lo,
	input wire logic [15:0] dig_hi,
	input wire logic [7:0] free_bits,
	// switch lines
	output logic [15:0] switch_input_word
);
	logic [7:0] dq = 8'hFF;
	always @* begin
		for (int p = 0; p < 4; p++)
			if (select_output_word[p])
				dq = {dig_hi[4*p+:4], dig_lo[4*p+:4]};
		switch_input_word = {free_bits, dq};
	end
endmodule // switch_bank
`default_nettype wire

// >>> bench/testbench.sv
// self-checking bench of the switch scanner
`timescale 1ns/100ps
`default_nettype none
`include "switch_scanner_defs.vh"
module testbench;
	logic core_clk = 1'h0;
	logic rst_n = 1'h0;
	logic wb_cyc_i = 1'h0;
	logic wb_stb_i = 1'h0;
	logic wb_we_i = 1'h0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [15:0] lo = 16'h0, hi = 16'h0;
	logic [7:0] fb = 8'h00;
	wire [31:0] wb_dat_o;
	wire wb_ack_o, busy, err, irq;
	wire [15:0] sw, sow;
	logic [31:0] rnd = 32'hF1F9, q;
	int n_mismatch = 0, tests_run = 0, k, t;
	always #2.5 core_clk = ~core_clk;
	switch_scanner i_dut (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.switch_input_word(sw), .select_output_word(sow),
		.switch_read_busy_flag(busy), .operand_error_flag(err), .irq(irq));
	switch_bank i_bank (.select_output_word(sow), .dig_lo(lo), .dig_hi(hi),
		.free_bits(fb), .switch_input_word(sw));
	function automatic [31:0] nx(input [31:0] v);
		nx = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function automatic [15:0] bcd(input [31:0] v);
		for (int j = 0; j < 4; j++)
			bcd[4*j+:4] = v[8*j+:4] % 4'hA;
	endfunction
	task automatic chk(input string nm, input [31:0] e, input [31:0] g);
		tests_run++;
		if (g !== e) begin
			$display("unexpected %s exp %h got %h", nm, e, g);
			n_mismatch++;
		end
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic tmo;
		n_mismatch++;
		stop_test;
	endtask
	task automatic wb(input [7:0] a, input w, input [31:0] d);
		int i;
		@(posedge core_clk);
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		for (i = 0; i < 20 && wb_ack_o !== 1'h1; i++)
			@(posedge core_clk);
		if (i == 20)
			tmo;
		q = wb_dat_o;
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
		@(posedge core_clk);
	endtask
	task automatic rc(input string nm, input [7:0] a, input [31:0] e);
		wb(a, 1'h0, 32'h0);
		chk(nm, e, q);
	endtask
	task automatic ce(input [31:0] p, input [31:0] e);
		wb(`OFS_PTR, 1'h1, p);
		repeat (4) @(posedge core_clk);
		chk("err", e, err);
	endtask
	task automatic wround;
		t = 0;
		while (sow[5] !== 1'h0 && t < 9000) begin
			@(posedge core_clk);
			t++;
		end
		while (sow[5] !== 1'h1 && t < 9000) begin
			@(posedge core_clk);
			t++;
		end
		if (t >= 9000)
			tmo;
	endtask
	initial begin
		repeat (12) @(posedge core_clk);
		rst_n <= 1'h1;
		@(posedge core_clk);
		chk("busy", 1, busy);
		rc("ctrl", `OFS_CTRL, 1);
		rc("unmapped", 8'h30, 0);
		for (k = 0; k < 3; k++) begin
			rnd = nx(rnd);
			lo <= bcd(rnd);
			fb <= rnd[31:24];
			rnd = nx(rnd);
			hi <= bcd(rnd);
			wb(`OFS_PTR, 1'h1, k == 1 ? 32'hE : k == 2 ? 32'h12 : 32'h0);
			wb(`OFS_CTRL, 1'h1, k == 2 ? 32'h3 : 32'h1);
			wround;
			wround;
			chk("round", 4000, t);
			repeat (8) @(posedge core_clk);
			t = k == 1 ? 14 : k == 2 ? 12 : 0;
			rc("low word", 8'(`OFS_AREA + 4 * t), lo);
			rc("high word", 8'(`OFS_AREA + 4 * t + 4), hi);
			chk("err", 0, err);
			$display("round test %0d done", k);
		end
		rc("ists", `OFS_ISTS, 3);
		wb(`OFS_IMASK, 1'h1, 1);
		chk("irq", 1, irq);
		wb(`OFS_IMASK, 1'h1, 0);
		chk("irq", 0, irq);
		wb(`OFS_ISTS, 1'h1, 3);
		rc("ists", `OFS_ISTS, 0);
		wb(`OFS_IMASK, 1'h1, 3);
		$display("interrupt test done");
		ce(32'h1A, 1);
		rc("ists", `OFS_ISTS, 2);
		chk("irq", 1, irq);
		ce(32'h12, 0);
		wb(`OFS_CTRL, 1'h1, 1);
		ce(32'hF, 1);
		ce(32'hE, 0);
		$display("error test done");
		rnd = nx(rnd);
		wb(`OFS_GPOUT, 1'h1, rnd);
		@(posedge core_clk);
		chk("gpout", rnd[15:6], sow[15:6]);
		wb(`OFS_GPIN, 1'h0, 32'h0);
		chk("gpin", fb, q[15:8]);
		wb(`OFS_CTRL, 1'h1, 0);
		chk("busy", 0, busy);
		repeat (5000) @(posedge core_clk);
		wb(`OFS_CTRL, 1'h1, 1);
		chk("busy", 1, busy);
		$display("free bits and run test done");
		stop_test;
	end
endmodule // testbench
`default_nettype wire
